// ==== common/tsr_defines.vh ====
// Register offsets, field positions and reset values of the test and status register bank.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH
`define TSR_ADDR_W 7
`define TSR_ADC_TEST_CTRL 7'h25
`define TSR_VGA_COUPLER_OVR 7'h26
`define TSR_VGA_STAGE_OVR 7'h27
`define TSR_PLL_PIN_STATUS 7'h40
`define TSR_SUBBLOCK_RST 7'h41
`define TSR_SIGNAL_STRENGTH 7'h42
`define TSR_AVG_FREQ_OFS 7'h43
`define TSR_INST_FREQ_OFS 7'h44
`define TSR_CAL_READOUT 7'h45
`define TSR_REV_VCO_READOUT 7'h46
`define TSR_FILTER_I_READ 7'h49
`define TSR_FILTER_Q_READ 7'h4A
`define TSR_ADC_TEST_RST 8'h40
`define TSR_COUPLER_RST 4'h0
`define TSR_STAGE_RST 6'h00
`define TSR_ROT_MODE_SEQ 2'h0
`define TSR_ROT_MODE_ALT 2'h1
`define TSR_ROT_MODE_FIXED 2'h2
`define TSR_ROT_MODE_HALF 2'h3
`define TSR_VGA_OVR_BIT 3
// Version value is arbitrary.
`define TSR_VERSION_CODE 3'h6
`endif

// ==== dv/test_transceiver_test_status_regs.sv ====
// Self-checking bench for the test and status register bank.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module test_transceiver_test_status_regs;
   logic clk = 1'b0, reset = 1'b1, adc_rotate_step = 1'b0, cal_e = 1'b0, seq_e = 1'b0, pend;
   logic [2:0] ev = 3'h0;
   logic [71:0] st = 72'h0;
   logic [95:0] r;
   logic [6:0] addr;
   logic [7:0] wdata, rdata, adc_test_ctrl, w, q[$];
   logic wr_en, rd_en, gain_override_en, first_coupler_manual_gain;
   logic [1:0] adc_rotation, second_coupler_manual_gain;
   logic [1:0] gain_stage1_manual, gain_stage2_manual, gain_stage3_manual;
   logic [7:0] rot[4] = '{8'hE4, 8'h78, 8'h00, 8'h88};
   logic [2:0] evs[6] = '{3'b010, 3'b001, 3'b100, 3'b011, 3'b101, 3'b110};
   int err_count = 0, total_checks = 0;
   always #12.5 clk = ~clk;
   tsr_host tsr_host_i (.clk, .addr, .wdata, .wr_en, .rd_en);
   // Version value is arbitrary.
   tsr_regs #(.SILICON_VERSION(3'h5)) tsr_regs_i (.*, .cal_start(ev[2]), .cal_finish(ev[1]),
      .powerup_lock_fail(ev[0]), .data_line_pin(st[0]), .data_clock_pin(st[1]),
      .lock_pin(st[2]), .pll_settled_filtered(st[3]), .pll_settled_now(st[4]),
      .carrier_threshold(st[11:5]), .signal_level(st[18:12]), .adc_init_finished(st[26]),
      .gain_ctrl_init_finished(st[25]), .shaping_filter_init_finished(st[24]),
      .decision_level_init_finished(st[23]), .modulator_init_finished(st[22]),
      .synthesizer_init_finished(st[21]), .sequencer_init_finished(st[20]),
      .cal_lock_init_finished(st[19]), .decision_level(st[34:27]),
      .instant_offset_value(st[42:35]), .applied_cal_dac(st[46:43]),
      .applied_pump_current(st[50:47]), .applied_oscillator_array(st[55:51]),
      .filter_i_out(st[63:56]), .filter_q_out(st[71:64]));
   ////////////////////////////////////////////////////////////////////////////////
   // Read data stands only one cycle, so the oldest note is compared right then.
   always @(negedge clk) begin
      if (pend)
         `CHK(rdata, q.pop_front())
      pend = rd_en;
   end
   task rdx(input logic [6:0] a, input logic [7:0] e);
      q.push_back(e);
      tsr_host_i.xfer(1'b0, a, 8'h00);
   endtask
   task evp(input logic [2:0] e);
      cal_e = e[1] | (cal_e & ~e[2]);
      seq_e = e[0] | (seq_e & ~e[2]);
      @(posedge clk);
      ev <= e;
      fork
         begin @(posedge clk); ev <= 3'h0; end
      join_none
      rdx(7'h40, {cal_e, seq_e, st[4:3], st[18:12] > st[11:5], st[2:0]});
   endtask
   task do_reset;
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h059d));
      do_reset;
      rdx(7'h25, 8'h40);
      rdx(7'h26, 8'h00);
      rdx(7'h27, 8'h00);
      rdx(7'h10, 8'h00);
      foreach (rot[m]) begin
         do_reset;
         tsr_host_i.xfer(1'b1, 7'h25, {6'h10, m[1:0]});
         for (int k = 1; k <= 4; k++) begin
            @(posedge clk);
            adc_rotate_step <= 1'b1;
            @(posedge clk);
            adc_rotate_step <= 1'b0;
            @(negedge clk);
            `CHK(adc_rotation, rot[m][2 * (k % 4) +: 2])
         end
         `CHK(adc_test_ctrl, {6'h10, m[1:0]})
      end
      $display("test rotation done");
      for (int i = 0; i < 16; i++) begin
         tsr_host_i.xfer(1'b1, 7'h26, 8'(i));
         // Override outputs are registered once more behind the stored field.
         repeat (2) @(negedge clk);
         `CHK({gain_override_en, first_coupler_manual_gain, second_coupler_manual_gain}, 4'(i))
         w = 8'($urandom) & 8'h3F;
         tsr_host_i.xfer(1'b1, 7'h27, w);
         repeat (2) @(negedge clk);
         `CHK({gain_stage1_manual, gain_stage2_manual, gain_stage3_manual}, w[5:0])
         rdx(7'h27, w);
      end
      $display("test overrides done");
      foreach (evs[j]) begin
         r = {$urandom, $urandom, $urandom};
         @(posedge clk);
         st <= r[71:0];
         tsr_host_i.xfer(1'b1, 7'h40, r[7:0]);
         evp(evs[j]);
         rdx(7'h41, st[26:19]);
         rdx(7'h43, st[34:27]);
         rdx(7'h44, st[42:35]);
         rdx(7'h45, {st[46:43], st[50:47]});
         rdx(7'h46, {3'h5, st[55:51]});
         rdx(7'h49, st[63:56]);
         rdx(7'h4A, st[71:64]);
      end
      $display("test status done");
      complete_run;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_count++;
      complete_run;
   end
endmodule // test_transceiver_test_status_regs
bind tsr_regs tsr_regs_monitor tsr_regs_monitor_i (.clk, .reset, .addr, .wdata, .wr_en,
   .rd_en, .rdata, .gain_stage1_manual, .cal_start, .cal_finish, .pll_settled_now,
   .signal_level, .carrier_threshold, .lock_pin, .data_clock_pin, .data_line_pin);

// ==== dv/tsr_host.sv ====
// Host model that issues one-cycle register writes and reads.
`timescale 1ns/1ps
module tsr_host (
   input wire clk,
   output logic [6:0] addr = 7'h00,
   output logic [7:0] wdata = 8'h00,
   output logic wr_en = 1'b0,
   output logic rd_en = 1'b0
);
   task xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      {wr_en, rd_en} <= {w, !w};
      @(posedge clk);
      {wr_en, rd_en} <= 2'b00;
   endtask
endmodule // tsr_host

// ==== dv/tsr_regs_monitor.sv ====
// Assertion checker for the test and status register bank.
`timescale 1ns/1ps
module tsr_regs_monitor (
   input wire clk,
   input wire reset,
   input wire [6:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] rdata,
   input wire [1:0] gain_stage1_manual,
   input wire cal_start,
   input wire cal_finish,
   input wire pll_settled_now,
   input wire [6:0] signal_level,
   input wire [6:0] carrier_threshold,
   input wire lock_pin,
   input wire data_clock_pin,
   input wire data_line_pin
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_cal_begun;
      cal_start && !cal_finish ##1 !cal_finish && rd_en && addr == 7'h40;
   endsequence
   sequence s_cal_ended;
      cal_finish ##1 !cal_start && rd_en && addr == 7'h40;
   endsequence
   AST_CAL_CLEAR: assert property (s_cal_begun |=> !rdata[7])
      else $error("cal flag not cleared");
   AST_CAL_SET: assert property (s_cal_ended |=> rdata[7])
      else $error("cal flag not set");
   AST_IDLE_ZERO: assert property (!rd_en |=> rdata == 8'h00)
      else $error("read data without read");
   AST_PIN_LEVELS: assert property (rd_en && addr == 7'h40 |=>
      rdata[2:0] == $past({lock_pin, data_clock_pin, data_line_pin})) else $error("pin bits");
   AST_LOCK_NOW: assert property (rd_en && addr == 7'h40 |=>
      rdata[5] == $past(pll_settled_now)) else $error("instant lock bit");
   AST_CARRIER: assert property (rd_en && addr == 7'h40 |=>
      rdata[3] == ($past(signal_level) > $past(carrier_threshold))) else $error("carrier bit");
   AST_STRENGTH: assert property (rd_en && addr == 7'h42 |=>
      rdata == {1'b0, $past(signal_level)}) else $error("strength value");
   AST_STAGE_WR: assert property (wr_en && addr == 7'h27 |=> ##1
      gain_stage1_manual == $past(wdata[5:4], 2)) else $error("stage override");
endmodule // tsr_regs_monitor

// ==== rtl/tsr_regs.v ====
// Test override and status register bank of the transceiver with ADC rotation sequencing.
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "tsr_defines.vh"
// Notes on behaviour
// - Rotation field picks ADC input rotation sequence.
// - First coupler override: 0 dB or -12 dB.
// - Second coupler override codes 0/-3/-12/-15 dB.
// - Three stage override fields; top bits reserved.
// - Calibration done clears at start, sets at end.
// - Sequence fault set when power-up lock fails.
// - Instant lock bit is raw detector output.
// - Filtered lock bit follows accuracy criterion.
// - Carrier sense set when strength exceeds threshold.
// - Low status bits show lock, clock, data pins.
// - Eight flags show sub-block reset completion.
// - Seven-bit strength, 1.5 dB steps, top zero.
// - Average offset is signed decision level.
// - Instant offset is signed IF deviation.
// - Calibration DAC and pump current readout.
// - Upper bits give silicon version code.
// - Lower bits give applied oscillator array.
// - Writes to main status change nothing.
// - Filter I and Q upper bits readable.
module tsr_regs #(
   // Arbitrary neutral version value.
   parameter [2:0] SILICON_VERSION = `TSR_VERSION_CODE
) (
   input wire clk,
   input wire reset,
   input wire [6:0] addr,
   input wire [7:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [7:0] rdata,
   input wire adc_rotate_step,
   output reg [1:0] adc_rotation,
   output reg [7:0] adc_test_ctrl,
   output reg gain_override_en,
   output reg first_coupler_manual_gain,
   output reg [1:0] second_coupler_manual_gain,
   output reg [1:0] gain_stage1_manual,
   output reg [1:0] gain_stage2_manual,
   output reg [1:0] gain_stage3_manual,
   input wire cal_start,
   input wire cal_finish,
   input wire powerup_lock_fail,
   input wire pll_settled_now,
   input wire pll_settled_filtered,
   input wire [6:0] carrier_threshold,
   input wire lock_pin,
   input wire data_clock_pin,
   input wire data_line_pin,
   input wire adc_init_finished,
   input wire gain_ctrl_init_finished,
   input wire shaping_filter_init_finished,
   input wire decision_level_init_finished,
   input wire modulator_init_finished,
   input wire synthesizer_init_finished,
   input wire sequencer_init_finished,
   input wire cal_lock_init_finished,
   input wire [6:0] signal_level,
   input wire [7:0] decision_level,
   input wire [7:0] instant_offset_value,
   input wire [3:0] applied_cal_dac,
   input wire [3:0] applied_pump_current,
   input wire [4:0] applied_oscillator_array,
   input wire [7:0] filter_i_out,
   input wire [7:0] filter_q_out
);

   reg [3:0] coupler_q;
   reg [5:0] stage_q;
   reg [7:0] adc_q;
   reg [1:0] rot_idx_q;
   reg [1:0] rot_idx_d;
   reg cal_done_q;
   reg seq_fault_q;
   reg [7:0] rd_mux;

   //////////////////////////////////////////////////////////////////////////////
   // Writable test registers.
   // reserved bits masked
   always @(posedge clk) begin
      if (reset) begin
         adc_q <= `TSR_ADC_TEST_RST;
         coupler_q <= `TSR_COUPLER_RST;
         stage_q <= `TSR_STAGE_RST;
      end else if (wr_en) begin
         case (addr)
            `TSR_ADC_TEST_CTRL: adc_q <= wdata;
            `TSR_VGA_COUPLER_OVR: coupler_q <= wdata[3:0];
            `TSR_VGA_STAGE_OVR: stage_q <= wdata[5:0];
            default: adc_q <= adc_q;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // ADC input rotation. The index counts steps; the mode maps it to a position.
   always @* begin
      rot_idx_d = rot_idx_q + 2'h1;
   end

   always @(posedge clk) begin
      if (reset) begin
         rot_idx_q <= 2'h0;
         adc_rotation <= 2'h0;
      end else if (adc_rotate_step) begin
         rot_idx_q <= rot_idx_d;
         case (adc_q[1:0])
            `TSR_ROT_MODE_SEQ: adc_rotation <= rot_idx_d;
            `TSR_ROT_MODE_ALT: begin
               case (rot_idx_d)
                  2'h0: adc_rotation <= 2'h0;
                  2'h1: adc_rotation <= 2'h2;
                  2'h2: adc_rotation <= 2'h3;
                  default: adc_rotation <= 2'h1;
               endcase
            end
            `TSR_ROT_MODE_FIXED: adc_rotation <= 2'h0;
            default: adc_rotation <= {rot_idx_d[0], 1'b0};
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Override outputs registered so downstream analog controls see clean levels.
   always @(posedge clk) begin
      if (reset) begin
         adc_test_ctrl <= `TSR_ADC_TEST_RST;
         gain_override_en <= 1'b0;
         first_coupler_manual_gain <= 1'b0;
         second_coupler_manual_gain <= 2'h0;
         gain_stage1_manual <= 2'h0;
         gain_stage2_manual <= 2'h0;
         gain_stage3_manual <= 2'h0;
      end else begin
         adc_test_ctrl <= adc_q;
         gain_override_en <= coupler_q[`TSR_VGA_OVR_BIT];
         first_coupler_manual_gain <= coupler_q[2];
         second_coupler_manual_gain <= coupler_q[1:0];
         gain_stage1_manual <= stage_q[5:4];
         gain_stage2_manual <= stage_q[3:2];
         gain_stage3_manual <= stage_q[1:0];
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Sticky PLL status. A finish in the same cycle as a start leaves the bit set.
   always @(posedge clk) begin
      if (reset) begin
         cal_done_q <= 1'b0;
         seq_fault_q <= 1'b0;
      end else begin
         if (cal_finish)
            cal_done_q <= 1'b1;
         else if (cal_start)
            cal_done_q <= 1'b0;
         if (powerup_lock_fail)
            seq_fault_q <= 1'b1;
         else if (cal_start)
            seq_fault_q <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////////
   // Read path. Unmapped addresses read zero.
   always @* begin
      rd_mux = 8'h00;
      case (addr)
         `TSR_ADC_TEST_CTRL: rd_mux = adc_q;
         `TSR_VGA_COUPLER_OVR: rd_mux = {4'h0, coupler_q};
         `TSR_VGA_STAGE_OVR: rd_mux = {2'h0, stage_q};
         `TSR_PLL_PIN_STATUS: rd_mux = {cal_done_q, seq_fault_q, pll_settled_now,
            pll_settled_filtered, (signal_level > carrier_threshold),
            lock_pin, data_clock_pin, data_line_pin};
         `TSR_SUBBLOCK_RST: rd_mux = {adc_init_finished, gain_ctrl_init_finished,
            shaping_filter_init_finished, decision_level_init_finished,
            modulator_init_finished, synthesizer_init_finished,
            sequencer_init_finished, cal_lock_init_finished};
         `TSR_SIGNAL_STRENGTH: rd_mux = {1'b0, signal_level};
         `TSR_AVG_FREQ_OFS: rd_mux = decision_level;
         `TSR_INST_FREQ_OFS: rd_mux = instant_offset_value;
         `TSR_CAL_READOUT: rd_mux = {applied_cal_dac, applied_pump_current};
         `TSR_REV_VCO_READOUT: rd_mux = {SILICON_VERSION, applied_oscillator_array};
         `TSR_FILTER_I_READ: rd_mux = filter_i_out;
         `TSR_FILTER_Q_READ: rd_mux = filter_q_out;
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (reset)
         rdata <= 8'h00;
      else if (rd_en)
         rdata <= rd_mux;
      else
         rdata <= 8'h00;
   end

endmodule // tsr_regs
